//--- logic/pmw_pkg.sv
// pmw_pkg: constants and types for the power mode and wakeup controller
package pmw_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned NUM_RES = 8;
  localparam int unsigned CPU_BIT = 0;
  localparam int unsigned NUM_IRQ = 4;
  localparam int unsigned IRQ_PERIPH = 0;
  localparam int unsigned IRQ_SUPV = 1;
  localparam int unsigned IRQ_TIMEWHEEL = 2;
  localparam int unsigned IRQ_IO = 3;
  localparam int unsigned SLEEP_RESUME_US = 15;
  localparam int unsigned SLEEP_RESUME_CYC = SLEEP_RESUME_US * CLK_MHZ;
  localparam int unsigned HIB_RESUME_US = 100;
  localparam int unsigned HIB_RESUME_CYC = HIB_RESUME_US * CLK_MHZ - 1;
  localparam int unsigned TIMEWHEEL_PERIOD = 2000;
  localparam logic [7:0] ACT_TMPL_RST = 8'hFF;
  localparam logic [7:0] ALT_TMPL_RST = 8'hFE;
  localparam logic [7:0] IRQ_EN_RST = 8'h0F;
  typedef enum logic [1:0] {
    MODE_ACTIVE,
    MODE_ALT_ACTIVE,
    MODE_SLEEP,
    MODE_HIBERNATE
  } pmw_mode_t;
endpackage

//--- logic/pmw_wake_if.sv
// pmw_wake_if: wakeup event carrier between the controller and its event collector
`timescale 1ns/1ps
`default_nettype none
interface pmw_wake_if;
  logic wake;
  logic io_wake;
  logic hib;
  modport src (output wake, output io_wake, input hib);
  modport dst (input wake, input io_wake, output hib);
endinterface
`default_nettype wire

//--- logic/pmw_timewheel.sv
// pmw_timewheel: divider that raises a periodic one-cycle tick
`timescale 1ns/1ps
`default_nettype none
module pmw_timewheel #(
  parameter int unsigned PERIOD = pmw_pkg::TIMEWHEEL_PERIOD
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic enable,
  output logic tick
);
  import pmw_pkg::*;
  logic [31:0] cnt_reg;
  always_ff @(posedge sys_clk) begin
    if (reset || !enable) begin
      cnt_reg <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_reg == PERIOD - 1) begin
      cnt_reg <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // pmw_timewheel
`default_nettype wire

//--- logic/pmw_wake_collect.sv
// pmw_wake_collect: synchronises pins and qualifies wakeup sources
`timescale 1ns/1ps
`default_nettype none
module pmw_wake_collect (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [pmw_pkg::NUM_IRQ-1:0] irq_in,
  input wire logic [pmw_pkg::NUM_IRQ-1:0] irq_en,
  input wire logic [2:0] rst_wake_en,
  input wire logic external_reset_pin_n,
  input wire logic [2:0] io_pin,
  input wire logic watchdog_timer,
  input wire logic precision_reset,
  pmw_wake_if.src wk
);
  import pmw_pkg::*;
  logic [2:0] xr_sync_reg;
  logic [2:0] io_s1_reg, io_s2_reg, io_s3_reg;
  logic xr_level_reg;
  logic [2:0] io_level_reg;
  logic io_edge;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      xr_sync_reg <= 3'h7;
      xr_level_reg <= 1'b0;
    end else begin
      xr_sync_reg <= {xr_sync_reg[1:0], external_reset_pin_n};
      if (xr_sync_reg[1] == xr_sync_reg[2]) begin
        xr_level_reg <= ~xr_sync_reg[2];
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      io_s1_reg <= 3'h0;
      io_s2_reg <= 3'h0;
      io_s3_reg <= 3'h0;
      io_level_reg <= 3'h0;
    end else begin
      io_s1_reg <= io_pin;
      io_s2_reg <= io_s1_reg;
      io_s3_reg <= io_s2_reg;
      for (int i = 0; i < 3; i++) begin
        if (io_s2_reg[i] == io_s3_reg[i]) begin
          io_level_reg[i] <= io_s3_reg[i];
        end
      end
    end
  end
  // io pins wake on a settled rising level change
  assign io_edge = |(io_s3_reg & ~io_level_reg & (io_s2_reg ~^ io_s3_reg));
  always_comb begin
    logic io_any;
    logic irq_any;
    logic rst_any;
    io_any = (irq_in[IRQ_IO] | io_edge) & irq_en[IRQ_IO];
    irq_any = |(irq_in & irq_en);
    rst_any = (xr_level_reg & rst_wake_en[0]) | (watchdog_timer & rst_wake_en[1]) |
      (precision_reset & rst_wake_en[2]);
    wk.io_wake = io_any;
    // in hibernate only external io may wake
    wk.wake = wk.hib ? io_any : (irq_any | io_any | rst_any);
  end
endmodule // pmw_wake_collect
`default_nettype wire

//--- logic/pmw_power_ctrl.sv
// pmw_power_ctrl: global power mode controller with templates and wakeup
// =====================================================================
`timescale 1ns/1ps
`default_nettype none
module pmw_power_ctrl #(
  parameter int unsigned SLEEP_CYC = pmw_pkg::SLEEP_RESUME_CYC,
  parameter int unsigned HIB_CYC = pmw_pkg::HIB_RESUME_CYC,
  parameter int unsigned TW_PERIOD = pmw_pkg::TIMEWHEEL_PERIOD
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic act_tmpl_wr,
  input wire logic [pmw_pkg::NUM_RES-1:0] act_tmpl_wdata,
  input wire logic alt_tmpl_wr,
  input wire logic [pmw_pkg::NUM_RES-1:0] alt_tmpl_wdata,
  input wire logic irq_en_wr,
  input wire logic [7:0] irq_en_wdata,
  input wire logic mode_req_wr,
  input wire pmw_pkg::pmw_mode_t mode_req,
  input wire logic periph_irq,
  input wire logic supervisor_irq,
  input wire logic io_irq,
  input wire logic [2:0] io_pin,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_timer,
  input wire logic precision_reset,
  input wire logic [pmw_pkg::NUM_RES-1:0] gpio_out_in,
  output logic [pmw_pkg::NUM_RES-1:0] res_enable,
  output logic [pmw_pkg::NUM_RES-1:0] res_clk_en,
  output logic [pmw_pkg::NUM_RES-1:0] gpio_out,
  output pmw_pkg::pmw_mode_t cur_mode,
  output logic resuming,
  output logic retain,
  output logic [pmw_pkg::NUM_RES-1:0] act_tmpl,
  output logic [pmw_pkg::NUM_RES-1:0] alt_tmpl,
  output logic [7:0] irq_en,
  output logic wake_event,
  output logic timewheel_tick
);
  import pmw_pkg::*;
  // =====================================================================
  // wakeup collection
  pmw_wake_if wk ();
  logic [NUM_IRQ-1:0] irq_vec;
  assign irq_vec = {io_irq, timewheel_tick, supervisor_irq, periph_irq};
  pmw_timewheel #(.PERIOD(TW_PERIOD)) u_tw (
    .sys_clk(sys_clk),
    .reset(reset),
    .enable(irq_en[IRQ_TIMEWHEEL]),
    .tick(timewheel_tick)
  );
  pmw_wake_collect u_wc (
    .sys_clk(sys_clk),
    .reset(reset),
    .irq_in(irq_vec),
    .irq_en(irq_en[NUM_IRQ-1:0]),
    .rst_wake_en(irq_en[6:4]),
    .external_reset_pin_n(external_reset_pin_n),
    .io_pin(io_pin),
    .watchdog_timer(watchdog_timer),
    .precision_reset(precision_reset),
    .wk(wk)
  );
  // =====================================================================
  // templates and enables written by firmware
  logic cpu_force_reg;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      act_tmpl <= ACT_TMPL_RST;
      alt_tmpl <= ALT_TMPL_RST;
      irq_en <= IRQ_EN_RST;
    end else begin
      if (act_tmpl_wr) begin
        act_tmpl <= act_tmpl_wdata;
      end
      if (alt_tmpl_wr) begin
        alt_tmpl <= alt_tmpl_wdata;
      end
      if (irq_en_wr) begin
        irq_en <= irq_en_wdata;
      end
    end
  end
  // =====================================================================
  // mode state machine
  typedef enum {ST_RUN, ST_LOW, ST_RESUME} pmw_state_t;
  pmw_state_t state_reg;
  pmw_mode_t mode_reg;
  logic [31:0] resume_cnt_reg;
  logic from_hib_reg;
  logic pend_reg;
  pmw_mode_t pend_mode_reg;
  assign wk.hib = (state_reg == ST_LOW) && (mode_reg == MODE_HIBERNATE);
  assign wake_event = wk.wake;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pend_reg <= 1'b0;
      pend_mode_reg <= MODE_ACTIVE;
    end else if (mode_req_wr) begin
      pend_reg <= 1'b1;
      pend_mode_reg <= mode_req;
    end else begin
      pend_reg <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= ST_RUN;
      mode_reg <= MODE_ACTIVE;
      resume_cnt_reg <= 32'h0;
      from_hib_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          if (wk.wake) begin
            mode_reg <= MODE_ACTIVE;
          end else if (pend_reg) begin
            mode_reg <= pend_mode_reg;
            if (pend_mode_reg == MODE_SLEEP || pend_mode_reg == MODE_HIBERNATE) begin
              state_reg <= ST_LOW;
            end
          end
        end
        ST_LOW: begin
          // hibernate listens to the io wake alone, every other source stays asleep
          if ((mode_reg == MODE_HIBERNATE) ? wk.io_wake : wk.wake) begin
            state_reg <= ST_RESUME;
            from_hib_reg <= (mode_reg == MODE_HIBERNATE);
            resume_cnt_reg <= 32'h0;
          end
        end
        ST_RESUME: begin
          // settle time before active; counted from the wake, sleep reaches active at exactly its resume figure, hibernate one cycle inside it
          if ((from_hib_reg && resume_cnt_reg >= HIB_CYC - 1) ||
              (!from_hib_reg && resume_cnt_reg >= SLEEP_CYC - 1)) begin
            state_reg <= ST_RUN;
            mode_reg <= MODE_ACTIVE;
          end else begin
            resume_cnt_reg <= resume_cnt_reg + 32'h1;
          end
        end
      endcase
    end
  end
  // cpu forced on in active mode from a wakeup until firmware rewrites the active template
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cpu_force_reg <= 1'b0;
    end else if (wk.wake) begin
      cpu_force_reg <= 1'b1;
    end else if (act_tmpl_wr) begin
      cpu_force_reg <= 1'b0;
    end
  end
  // =====================================================================
  // resource enables and clock gating
  logic [NUM_RES-1:0] en_next;
  always_comb begin
    en_next = '0;
    if (state_reg == ST_RUN) begin
      if (mode_reg == MODE_ALT_ACTIVE) begin
        en_next = alt_tmpl;
      end else begin
        en_next = act_tmpl;
        en_next[CPU_BIT] = act_tmpl[CPU_BIT] | cpu_force_reg;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      res_enable <= ACT_TMPL_RST;
      res_clk_en <= ACT_TMPL_RST;
    end else begin
      res_enable <= en_next;
      res_clk_en <= en_next;
    end
  end
  // outputs freeze while retained in hibernate
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      gpio_out <= '0;
    end else if (!wk.hib) begin
      gpio_out <= gpio_out_in;
    end
  end
  assign retain = wk.hib;
  assign cur_mode = mode_reg;
  assign resuming = (state_reg == ST_RESUME);
endmodule // pmw_power_ctrl
`default_nettype wire

//--- bench/pmw_src_model.sv
// pmw_src_model: firmware-side wakeup sources and pins facing the controller
`timescale 1ns/1ps
`default_nettype none
module pmw_src_model (
  input wire logic sys_clk,
  output logic [6:0] src
);
  // bits: 0 periph, 1 supervisor, 2 io pin, 3 io irq, 4 reset pin (low active), 5 watchdog,
  // 6 precision reset; the reset pin idles high
  initial src = 7'h10;
  // a source is held n cycles so it clears the pin synchronisers and filter
  task automatic fire(input int b, input int n);
    @(posedge sys_clk);
    #1 src[b] = ~src[b];
    repeat (n) @(posedge sys_clk);
    // pins used in hibernate are held at least 10000 cycles
    #1 src[b] = ~src[b];
  endtask
endmodule // pmw_src_model
`default_nettype wire

//--- bench/pmw_power_ctrl_assertions.sv
// pmw_power_ctrl_assertions: port-level checks of the power mode controller
`timescale 1ns/1ps
`default_nettype none
module pmw_power_ctrl_assertions #(
  parameter int unsigned SLEEP_CYC = 4,
  parameter int unsigned HIB_CYC = 6
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic act_tmpl_wr,
  input wire logic [pmw_pkg::NUM_RES-1:0] act_tmpl_wdata,
  input wire logic io_irq,
  input wire logic [2:0] io_pin,
  input wire logic [pmw_pkg::NUM_RES-1:0] res_enable,
  input wire logic [pmw_pkg::NUM_RES-1:0] res_clk_en,
  input wire pmw_pkg::pmw_mode_t cur_mode,
  input wire logic resuming,
  input wire logic [pmw_pkg::NUM_RES-1:0] act_tmpl,
  input wire logic wake_event
);
  import pmw_pkg::*;
  // two spare cycles cover the wake and the final mode register
  localparam int S_MAX = SLEEP_CYC + 2;
  localparam int H_MAX = HIB_CYC + 2;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  property p_boot;
    $fell(reset) |-> cur_mode == MODE_ACTIVE && res_enable == 8'hFF;
  endproperty
  a_boot: assert property (p_boot) else $error("boot state");
  property p_gate;
    (res_clk_en & ~res_enable) == 8'h00;
  endproperty
  a_gate: assert property (p_gate) else $error("clock not gated");
  property p_rd;
    act_tmpl_wr |=> act_tmpl == $past(act_tmpl_wdata);
  endproperty
  a_rd: assert property (p_rd) else $error("template write lost");
  property p_act;
    cur_mode == MODE_ACTIVE && $past(cur_mode) == MODE_ACTIVE && $stable(act_tmpl)
      |-> res_enable[7:1] == act_tmpl[7:1];
  endproperty
  a_act: assert property (p_act) else $error("enable differs from template");
  property p_wake;
    wake_event && !resuming && (cur_mode == MODE_ACTIVE || cur_mode == MODE_ALT_ACTIVE)
      |-> ##[1:2] (cur_mode == MODE_ACTIVE && res_enable[CPU_BIT]);
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not force cpu");
  property p_sleep;
    cur_mode == MODE_SLEEP && !resuming && wake_event
      |=> resuming ##[1:S_MAX] cur_mode == MODE_ACTIVE;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep resume late");
  property p_hib;
    cur_mode == MODE_HIBERNATE && !resuming && wake_event
      |=> resuming ##[1:H_MAX] cur_mode == MODE_ACTIVE;
  endproperty
  a_hib: assert property (p_hib) else $error("hibernate resume late");
  property p_io;
    cur_mode == MODE_HIBERNATE && !resuming && !io_irq && io_pin == $past(io_pin, 8)
      |-> !wake_event;
  endproperty
  a_io: assert property (p_io) else $error("non-io wake in hibernate");
endmodule // pmw_power_ctrl_assertions
bind pmw_power_ctrl pmw_power_ctrl_assertions #(.SLEEP_CYC(SLEEP_CYC), .HIB_CYC(HIB_CYC))
  i_pmw_power_ctrl_assertions (.*);
`default_nettype wire

//--- bench/tb.sv
// tb: self-checking bench for the power mode controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
  import pmw_pkg::*;
  logic sys_clk = 0;
  logic reset = 1;
  logic [3:0] stb = 0;
  logic [7:0] wd = 0, gin = 0, d, res_enable, res_clk_en, gpio_out, act_tmpl, alt_tmpl, irq_en;
  logic [6:0] src;
  logic resuming, retain, wake_event, tw_tick;
  logic [7:0] ticks;
  localparam int TW = 8;
  pmw_mode_t cur_mode;
  int fail_count = 0, total_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  pmw_src_model i_pmw_src_model (.sys_clk(sys_clk), .src(src));
  pmw_power_ctrl #(.SLEEP_CYC(4), .HIB_CYC(6), .TW_PERIOD(TW)) i_pmw_power_ctrl (
    .sys_clk(sys_clk), .reset(reset), .act_tmpl_wr(stb[0]), .act_tmpl_wdata(wd),
    .alt_tmpl_wr(stb[1]), .alt_tmpl_wdata(wd), .irq_en_wr(stb[2]), .irq_en_wdata(wd),
    .mode_req_wr(stb[3]), .mode_req(pmw_mode_t'(wd[1:0])), .periph_irq(src[0]),
    .supervisor_irq(src[1]), .io_irq(src[3]), .io_pin({2'h0, src[2]}),
    .external_reset_pin_n(src[4]), .watchdog_timer(src[5]), .precision_reset(src[6]),
    .gpio_out_in(gin), .res_enable(res_enable), .res_clk_en(res_clk_en),
    .gpio_out(gpio_out), .cur_mode(cur_mode), .resuming(resuming), .retain(retain),
    .act_tmpl(act_tmpl), .alt_tmpl(alt_tmpl), .irq_en(irq_en), .wake_event(wake_event),
    .timewheel_tick(tw_tick));
  function automatic logic [7:0] exp_en(input logic [7:0] t, input logic cpu_on);
    return t | {7'h00, cpu_on};
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // k: 0 active template, 1 alternate template, 2 wake enables, 3 mode request
  task automatic wr(input int k, input logic [7:0] v);
    @(posedge sys_clk);
    #1 stb[k] = 1'b1;
    wd = v;
    @(posedge sys_clk);
    #1 stb = 4'h0;
  endtask
  task automatic wait_mode(input pmw_mode_t m);
    int i;
    for (i = 0; i < 400 && cur_mode !== m; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (i == 400) begin
      fail_count++;
      stop_test();
    end
    // one more edge so the registered enables follow the new mode
    @(posedge sys_clk);
    #1;
  endtask
  // the enable bit index matches the source bit; the timewheel wakes by itself
  task automatic sleep_wake(input int b);
    wr(2, 8'h01 << b);
    wr(3, 8'h02);
    wait_mode(MODE_SLEEP);
    if (b != 2) i_pmw_src_model.fire(b, 20);
    wait_mode(MODE_ACTIVE);
    `CHK(res_enable[0], 1'b1)
  endtask
  initial begin
    void'($urandom(32'h53ecc0fe));
    repeat (20) @(posedge sys_clk);
    #1 reset = 1'b0;
    `CHK(cur_mode, MODE_ACTIVE)
    `CHK({res_enable, res_clk_en, act_tmpl, alt_tmpl, irq_en, gpio_out}, 48'hFFFFFFFE0F00)
    $display("test boot done");
    // wakes off, so a stray tick cannot force the cpu bit during the template loop
    wr(2, 8'h00);
    repeat (8) begin
      d = 8'($urandom);
      wr(0, d);
      @(posedge sys_clk);
      #1;
      `CHK(res_enable, exp_en(d, 1'b0))
      `CHK(res_clk_en, res_enable)
    end
    wr(0, 8'hFE);
    wr(2, 8'h01);
    i_pmw_src_model.fire(0, 20);
    `CHK(res_enable, exp_en(8'hFE, 1'b1))
    $display("test template done");
    wr(2, 8'h00);
    wr(3, 8'h02);
    wait_mode(MODE_SLEEP);
    i_pmw_src_model.fire(0, 20);
    `CHK({cur_mode, res_enable}, {MODE_SLEEP, 8'h00})
    for (int b = 0; b < 7; b++) sleep_wake(b);
    $display("test sleep done");
    wr(2, 8'h04);
    ticks = 8'h00;
    repeat (32) begin
      @(posedge sys_clk);
      #1 ticks += {7'h00, tw_tick};
    end
    `CHK(ticks, 8'(32 / TW))
    wr(2, 8'h40);
    $display("test timewheel done");
    wr(0, 8'hFF);
    d = 8'($urandom) & 8'hFE;
    wr(1, d);
    wr(3, 8'h01);
    wait_mode(MODE_ALT_ACTIVE);
    repeat (2) @(posedge sys_clk);
    `CHK({alt_tmpl, res_enable}, {d, d})
    i_pmw_src_model.fire(6, 20);
    `CHK({cur_mode, res_enable}, {MODE_ACTIVE, 8'hFF})
    $display("test alternate done");
    // timewheel left off: a tick on the request cycle would cancel the request
    wr(2, 8'h7B);
    gin = 8'($urandom);
    d = gin;
    wr(3, 8'h03);
    wait_mode(MODE_HIBERNATE);
    gin = ~d;
    i_pmw_src_model.fire(5, 20);
    `CHK({cur_mode, retain, gpio_out}, {MODE_HIBERNATE, 1'b1, d})
    i_pmw_src_model.fire(2, 10000);
    `CHK(cur_mode, MODE_ACTIVE)
    $display("test hibernate done");
    wr(3, 8'h01);
    wait_mode(MODE_ALT_ACTIVE);
    wr(3, 8'h00);
    wait_mode(MODE_ACTIVE);
    `CHK({cur_mode, res_enable}, {MODE_ACTIVE, 8'hFF})
    $display("test request done");
    stop_test();
  end
endmodule // tb
`default_nettype wire
